// ==== src/ipip_pkg.sv ====
package ipip_pkg;
    // Clock and timing
    localparam int CLK_KHZ = 25000;
    localparam int CLK_NS = 40;
    localparam int OSC_KHZ = 2048;
    localparam int SAMPLE_NS = 82030;
    localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
    localparam int ACC_W = 16;
    localparam int TMR_W = 12;

    // Gimbal angle counters
    localparam int ANGLE_W = 11;
    localparam int DIFF_W = 12;
    localparam int DIFF_LO = -4;
    localparam int DIFF_HI = 3;
    localparam int FAULT_LIMIT = 3;
    localparam int FAULT_W = 2;
    localparam int WORD_W = 12;
    localparam int FLAG_BIT = 11;
    localparam int BITS_W = 4;
    localparam int CTR_A = 0;
    localparam int CTR_B = 1;

    // Velocity storage
    localparam int VEL_W = 12;
    localparam int PHASE_W = 2;
    localparam int HIGH_W = 10;
    localparam int NUM_AXES = 3;
    localparam int NUM_WORDS = 6;
    localparam int ADDR_W = 3;
    localparam int PHASE_B = 0;
    localparam int PHASE_C = 1;
    localparam logic [1:0] BIN_WRAP_LO = 2'h0;
    localparam logic [1:0] BIN_WRAP_HI = 2'h3;

    typedef enum logic [2:0] {
        IPIP_IDLE, IPIP_READ, IPIP_WRITE, IPIP_HREAD, IPIP_HDONE
    } ipip_acc_state_t;

    // Word index is axis*2+channel; address is line*2+phase
    function automatic logic [ADDR_W-1:0] ipip_slot_addr(
        input logic [ADDR_W-1:0] idx);
        logic [1:0] axis;
        logic [1:0] line;
        axis = idx[2:1];
        if (idx[0] == 1'b0) begin
            line = (axis == 2'h2) ? 2'h0 : axis + 2'h1;
            return {line, 1'b0};
        end
        line = axis;
        return {line, 1'b1};
    endfunction

    function automatic logic [1:0] ipip_refl2bin(input logic [1:0] g);
        return {g[1], g[1] ^ g[0]};
    endfunction
endpackage

// ==== src/ipip_mem_if.sv ====
`timescale 1ns/10ps
interface ipip_mem_if #(
    parameter int AW = 3,
    parameter int DW = 12
);
    logic [AW-1:0] addr;
    logic rd_en;
    logic wr_en;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport user (output addr, output rd_en, output wr_en,
        output wdata, input rdata);
    modport store (input addr, input rd_en, input wr_en,
        input wdata, output rdata);
endinterface

// ==== src/ipip_vel_store.sv ====
`timescale 1ns/10ps
module ipip_vel_store #(
    parameter int DEPTH = 6,
    parameter int DW = 12
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Storage port
    ipip_mem_if.store mem
);
    logic [DW-1:0] word_q [DEPTH];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                word_q[i] <= '0;
            end
        end else if (mem.wr_en) begin
            word_q[mem.addr] <= mem.wdata;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= '0;
        end else if (mem.rd_en) begin
            rdata_q <= word_q[mem.addr];
        end
    end

    assign mem.rdata = rdata_q;
endmodule // ipip_vel_store

// ==== src/ipip_input_proc.sv ====
`timescale 1ns/10ps
module ipip_input_proc
    import ipip_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Resolver crossover detectors
    input wire logic start_xover_in,
    input wire logic stop_xover_in,
    // Computation cycle and counter choice from the flight computer
    input wire logic comp_cycle_in,
    input wire logic ctr_sel_in,
    // Gimbal angle input transfer
    input wire logic angle_rd_req_in,
    output logic angle_ready_out,
    output logic angle_ser_data_out,
    output logic angle_ser_en_out,
    output logic disagree_out,
    output logic flag_inhibit_out,
    // Encoder phase pairs {high, low}, index axis*2+channel
    input wire logic [2*ipip_pkg::NUM_WORDS-1:0] enc_phase_in,
    // Velocity input transfer
    input wire logic vel_rd_req_in,
    input wire logic [ipip_pkg::ADDR_W-1:0] vel_rd_sel_in,
    output logic [ipip_pkg::VEL_W-1:0] vel_word_out,
    output logic vel_valid_out
);
    import ipip_pkg::*;

    function automatic logic [DIFF_W-1:0] sext(
        input logic [ANGLE_W-1:0] v);
        return {v[ANGLE_W-1], v};
    endfunction

    // 2.048 MHz counting tick from a fractional accumulator
    logic [ACC_W-1:0] osc_acc_q;
    logic osc_tick_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_acc_q <= '0;
            osc_tick_q <= 1'b0;
        end else if (osc_acc_q + ACC_W'(OSC_KHZ) >= ACC_W'(CLK_KHZ)) begin
            osc_acc_q <= osc_acc_q + ACC_W'(OSC_KHZ) - ACC_W'(CLK_KHZ);
            osc_tick_q <= 1'b1;
        end else begin
            osc_acc_q <= osc_acc_q + ACC_W'(OSC_KHZ);
            osc_tick_q <= 1'b0;
        end
    end

    // Angle counters
    logic run_q;
    logic [ANGLE_W-1:0] cnt_a_q;
    logic [ANGLE_W-1:0] cnt_b_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_q <= 1'b0;
        end else if (start_xover_in) begin
            run_q <= 1'b1;
        end else if (stop_xover_in) begin
            run_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_a_q <= '0;
            cnt_b_q <= '0;
        end else if (start_xover_in) begin
            cnt_a_q <= '0;
            cnt_b_q <= '0;
        end else if (run_q && osc_tick_q && !stop_xover_in) begin
            cnt_a_q <= cnt_a_q + 1'b1;
            cnt_b_q <= cnt_b_q + 1'b1;
        end
    end

    // Difference check
    logic signed [DIFF_W-1:0] diff;
    logic diff_bad;
    logic fault;

    always_comb begin
        // Wrapped 11-bit difference read as signed, so counter wrap is benign
        diff = $signed(sext(cnt_a_q - cnt_b_q));
        diff_bad = (diff < DIFF_W'(DIFF_LO)) || (diff > DIFF_W'(DIFF_HI));
        fault = stop_xover_in && run_q && diff_bad;
    end

    // Fault tally per computation cycle and counter lock
    logic [FAULT_W-1:0] fault_cnt_q;
    logic lock_q;
    logic good_ctr_q;
    logic use_b;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_cnt_q <= '0;
        end else if (fault && !lock_q) begin
            fault_cnt_q <= fault_cnt_q + 1'b1;
        end else if (comp_cycle_in) begin
            fault_cnt_q <= '0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_q <= 1'b0;
            good_ctr_q <= 1'b0;
        end else if (fault && !lock_q &&
                     fault_cnt_q == FAULT_W'(FAULT_LIMIT - 1)) begin
            lock_q <= 1'b1;
            good_ctr_q <= ctr_sel_in;
        end
    end

    assign use_b = lock_q ? good_ctr_q : ctr_sel_in;

    // Held angle word
    logic [WORD_W-1:0] held_q;
    logic ready_q;
    logic disagree_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_q <= '0;
            disagree_q <= 1'b0;
        end else if (stop_xover_in && run_q) begin
            held_q[ANGLE_W-1:0] <= use_b ? cnt_b_q : cnt_a_q;
            held_q[FLAG_BIT] <= diff_bad && !lock_q;
            disagree_q <= diff_bad && !lock_q;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_q <= 1'b0;
        end else if (stop_xover_in && run_q) begin
            ready_q <= 1'b1;
        end else if (angle_rd_req_in) begin
            ready_q <= 1'b0;
        end
    end

    // Serial shifter, MSB first
    logic [WORD_W-1:0] shift_q;
    logic [BITS_W-1:0] bits_left_q;
    logic ser_data_q;
    logic ser_en_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= '0;
            bits_left_q <= '0;
            ser_data_q <= 1'b0;
            ser_en_q <= 1'b0;
        end else if (angle_rd_req_in && bits_left_q == '0) begin
            shift_q <= held_q << 1;
            bits_left_q <= BITS_W'(WORD_W - 1);
            ser_data_q <= held_q[WORD_W-1];
            ser_en_q <= 1'b1;
        end else if (bits_left_q != '0) begin
            shift_q <= shift_q << 1;
            bits_left_q <= bits_left_q - 1'b1;
            ser_data_q <= shift_q[WORD_W-1];
            ser_en_q <= 1'b1;
        end else begin
            ser_data_q <= 1'b0;
            ser_en_q <= 1'b0;
        end
    end

    // Encoder sample period
    logic [TMR_W-1:0] samp_cnt_q;
    logic samp_pend_q;
    logic host_pend_q;
    logic [ADDR_W-1:0] host_sel_q;
    logic [2*NUM_WORDS-1:0] samp_q;
    ipip_acc_state_t state_q;
    logic [ADDR_W-1:0] slot_q;
    logic samp_take;
    logic host_take;

    assign samp_take = (state_q == IPIP_IDLE) && samp_pend_q;
    assign host_take = (state_q == IPIP_IDLE) && !samp_pend_q &&
        host_pend_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            samp_cnt_q <= '0;
        end else if (samp_cnt_q == TMR_W'(SAMPLE_CYCLES - 1)) begin
            samp_cnt_q <= '0;
        end else begin
            samp_cnt_q <= samp_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            samp_pend_q <= 1'b0;
            samp_q <= '0;
        end else if (samp_cnt_q == TMR_W'(SAMPLE_CYCLES - 1)) begin
            samp_pend_q <= 1'b1;
            samp_q <= enc_phase_in;
        end else if (samp_take) begin
            samp_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            host_pend_q <= 1'b0;
            host_sel_q <= '0;
        end else if (vel_rd_req_in) begin
            // A request on the taking edge is served by that same read
            host_pend_q <= !host_take;
            host_sel_q <= vel_rd_sel_in;
        end else if (host_take) begin
            host_pend_q <= 1'b0;
        end
    end

    // Accumulator sweep over the six stored words
    ipip_mem_if #(.AW(ADDR_W), .DW(VEL_W)) mem ();

    ipip_vel_store #(.DEPTH(NUM_WORDS), .DW(VEL_W)) u_store (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .mem(mem.store)
    );

    logic [1:0] new_bin;
    logic [1:0] old_bin;
    logic [HIGH_W-1:0] high_old;
    logic [HIGH_W-1:0] high_new;

    always_comb begin
        new_bin = ipip_refl2bin(samp_q[2*slot_q +: 2]);
        old_bin = mem.rdata[PHASE_W-1:0];
        high_old = mem.rdata[VEL_W-1:PHASE_W];
        high_new = high_old;
        // Forward steps count down in true binary, so 0->3 wraps forward
        if (old_bin == BIN_WRAP_LO && new_bin == BIN_WRAP_HI) begin
            high_new = high_old + 1'b1;
        end else if (old_bin == BIN_WRAP_HI && new_bin == BIN_WRAP_LO) begin
            high_new = high_old - 1'b1;
        end
    end

    always_comb begin
        mem.rd_en = 1'b0;
        mem.wr_en = 1'b0;
        mem.addr = ipip_slot_addr(slot_q);
        mem.wdata = {high_new, new_bin};
        case (state_q)
            IPIP_READ: begin
                mem.rd_en = 1'b1;
            end
            IPIP_WRITE: begin
                mem.wr_en = 1'b1;
            end
            IPIP_HREAD: begin
                mem.rd_en = 1'b1;
                mem.addr = ipip_slot_addr(host_sel_q);
            end
            default: begin
                mem.rd_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= IPIP_IDLE;
            slot_q <= '0;
        end else begin
            case (state_q)
                IPIP_IDLE: begin
                    slot_q <= '0;
                    if (samp_take) begin
                        state_q <= IPIP_READ;
                    end else if (host_take) begin
                        state_q <= IPIP_HREAD;
                    end
                end
                IPIP_READ: begin
                    state_q <= IPIP_WRITE;
                end
                IPIP_WRITE: begin
                    if (slot_q == ADDR_W'(NUM_WORDS - 1)) begin
                        state_q <= IPIP_IDLE;
                    end else begin
                        slot_q <= slot_q + 1'b1;
                        state_q <= IPIP_READ;
                    end
                end
                IPIP_HREAD: begin
                    state_q <= IPIP_HDONE;
                end
                IPIP_HDONE: begin
                    state_q <= IPIP_IDLE;
                end
                default: begin
                    state_q <= IPIP_IDLE;
                end
            endcase
        end
    end

    // Velocity word return
    logic [VEL_W-1:0] vel_word_q;
    logic vel_valid_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vel_word_q <= '0;
            vel_valid_q <= 1'b0;
        end else if (state_q == IPIP_HDONE) begin
            vel_word_q <= mem.rdata;
            vel_valid_q <= 1'b1;
        end else begin
            vel_valid_q <= 1'b0;
        end
    end

    assign angle_ready_out = ready_q;
    assign angle_ser_data_out = ser_data_q;
    assign angle_ser_en_out = ser_en_q;
    assign disagree_out = disagree_q;
    assign flag_inhibit_out = lock_q;
    assign vel_word_out = vel_word_q;
    assign vel_valid_out = vel_valid_q;
endmodule // ipip_input_proc

// ==== test/ipip_input_proc_sva.sv ====
`timescale 1ns/10ps
module ipip_input_proc_sva
    import ipip_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Angle path
    input wire logic start_xover_in,
    input wire logic stop_xover_in,
    input wire logic angle_rd_req_in,
    input wire logic angle_ready_out,
    input wire logic angle_ser_data_out,
    input wire logic angle_ser_en_out,
    input wire logic disagree_out,
    input wire logic flag_inhibit_out,
    // Velocity path
    input wire logic vel_rd_req_in,
    input wire logic [ipip_pkg::VEL_W-1:0] vel_word_out,
    input wire logic vel_valid_out
);
    logic run_q;
    logic [3:0] en_cnt_q;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Mirrors whether the angle counters are running
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_q <= 1'b0;
        end else if (start_xover_in) begin
            run_q <= 1'b1;
        end else if (stop_xover_in) begin
            run_q <= 1'b0;
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_cnt_q <= 4'h0;
        end else begin
            en_cnt_q <= angle_ser_en_out ? en_cnt_q + 4'h1 : 4'h0;
        end
    end
    chk_ready_on_stop: assert property (
        stop_xover_in && run_q && !start_xover_in |-> ##[1:2] angle_ready_out)
        else $error("ready missing after stop");
    chk_ser_on_req: assert property (
        angle_rd_req_in && angle_ready_out && !angle_ser_en_out
        && !(stop_xover_in && run_q)
        |-> ##[1:2] (angle_ser_en_out && !angle_ready_out))
        else $error("shift did not start on request");
    chk_ser_length: assert property (
        $fell(angle_ser_en_out) |-> en_cnt_q == 4'hC)
        else $error("shift length is not twelve");
    chk_ser_bound: assert property (
        angle_ser_en_out |-> en_cnt_q < 4'hC)
        else $error("shift runs too long");
    chk_flag_first: assert property (
        $rose(angle_ser_en_out) |-> angle_ser_data_out == disagree_out)
        else $error("first bit is not the flag");
    chk_agree_flag: assert property (
        disagree_out == 1'b0)
        else $error("flag set with agreeing counters");
    chk_no_lock: assert property (
        flag_inhibit_out == 1'b0)
        else $error("lock without faults");
    chk_ready_hold: assert property (
        angle_ready_out && !angle_rd_req_in && !$past(angle_rd_req_in)
        |=> angle_ready_out)
        else $error("ready dropped without request");
    chk_vel_answer: assert property (
        vel_rd_req_in |-> ##[3:20] vel_valid_out)
        else $error("velocity read not answered");
    chk_vel_hold: assert property (
        !vel_valid_out |-> $stable(vel_word_out))
        else $error("velocity word changed between reads");
endmodule // ipip_input_proc_sva

bind ipip_input_proc ipip_input_proc_sva #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_sva (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .start_xover_in(start_xover_in),
    .stop_xover_in(stop_xover_in),
    .angle_rd_req_in(angle_rd_req_in),
    .angle_ready_out(angle_ready_out),
    .angle_ser_data_out(angle_ser_data_out),
    .angle_ser_en_out(angle_ser_en_out),
    .disagree_out(disagree_out),
    .flag_inhibit_out(flag_inhibit_out),
    .vel_rd_req_in(vel_rd_req_in),
    .vel_word_out(vel_word_out),
    .vel_valid_out(vel_valid_out)
);

// ==== test/ipip_enc_model.sv ====
`timescale 1ns/10ps
module ipip_enc_model
    import ipip_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Step commands, one bit per word
    input wire logic [ipip_pkg::NUM_WORDS-1:0] fwd_in,
    input wire logic [ipip_pkg::NUM_WORDS-1:0] rev_in,
    // Encoder phase pairs {high, low}
    output logic [2*ipip_pkg::NUM_WORDS-1:0] enc_phase_out
);
    logic [1:0] pos_q [NUM_WORDS];
    // Position kept in true binary; forward runs 1,0,3,2
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        for (int i = 0; i < NUM_WORDS; i++) begin
            if (!rst_n_in) begin
                pos_q[i] <= 2'h0;
            end else if (fwd_in[i]) begin
                pos_q[i] <= pos_q[i] - 2'h1;
            end else if (rev_in[i]) begin
                pos_q[i] <= pos_q[i] + 2'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NUM_WORDS; i++) begin
            enc_phase_out[2*i+:2] =
                {pos_q[i][1], pos_q[i][1] ^ pos_q[i][0]};
        end
    end
endmodule // ipip_enc_model

// ==== test/test_inertial_platform_input_processing.sv ====
`timescale 1ns/10ps
module test_inertial_platform_input_processing;
    import ipip_pkg::*;
    localparam int SCYC = 20;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic start_xover_in = 1'b0;
    logic stop_xover_in = 1'b0;
    logic comp_cycle_in = 1'b0;
    logic ctr_sel_in = 1'b0;
    logic angle_rd_req_in = 1'b0;
    logic vel_rd_req_in = 1'b0;
    logic [ADDR_W-1:0] vel_rd_sel_in = 3'h0;
    logic [NUM_WORDS-1:0] fwd = 6'h0;
    logic [NUM_WORDS-1:0] rev = 6'h0;
    logic [2*NUM_WORDS-1:0] enc_phase;
    logic angle_ready_out, angle_ser_data_out, angle_ser_en_out;
    logic disagree_out, flag_inhibit_out, vel_valid_out;
    logic [VEL_W-1:0] vel_word_out;
    logic [WORD_W-1:0] exp_vel[$], exp_ang[$], sh;
    logic [HIGH_W-1:0] hi [NUM_WORDS];
    logic [1:0] ph [NUM_WORDS];
    int err_count = 0, n_compared = 0, nbits = 0, n_vel = 0, cyc = 0;

    always #20 core_clk_in = ~core_clk_in;

    ipip_input_proc #(.SAMPLE_CYCLES(SCYC)) u_dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .start_xover_in(start_xover_in), .stop_xover_in(stop_xover_in),
        .comp_cycle_in(comp_cycle_in), .ctr_sel_in(ctr_sel_in),
        .angle_rd_req_in(angle_rd_req_in), .angle_ready_out(angle_ready_out),
        .angle_ser_data_out(angle_ser_data_out),
        .angle_ser_en_out(angle_ser_en_out), .disagree_out(disagree_out),
        .flag_inhibit_out(flag_inhibit_out), .enc_phase_in(enc_phase),
        .vel_rd_req_in(vel_rd_req_in), .vel_rd_sel_in(vel_rd_sel_in),
        .vel_word_out(vel_word_out), .vel_valid_out(vel_valid_out));

    ipip_enc_model u_enc (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .fwd_in(fwd),
        .rev_in(rev), .enc_phase_out(enc_phase));

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic fail(string m);
        $display("[FAIL] %0t %s", $time, m);
        err_count++;
    endtask

    task automatic chk(logic ok, string m);
        n_compared++;
        if (ok !== 1'b1) fail(m);
    endtask

    task automatic cmp_vel(logic [VEL_W-1:0] got);
        if (exp_vel.size() == 0) begin
            chk(1'b0, "unexpected velocity word");
        end else begin
            chk(got === exp_vel.pop_front(), "velocity mismatch");
        end
    endtask

    task automatic cmp_ang(logic [WORD_W-1:0] got, int n);
        logic [WORD_W-1:0] e;
        logic [ANGLE_W-1:0] d;
        if (exp_ang.size() == 0) begin
            chk(1'b0, "unexpected angle word");
        end else begin
            e = exp_ang.pop_front();
            d = got[10:0] - e[10:0] + 11'h1;
            chk(n == 12 && got[11] === e[11] && d < 11'h4,
                "angle mismatch");
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    task automatic angle_test(int k);
        logic [WORD_W-1:0] e;
        int t;
        e = {1'b0, 11'((k * 2048) / 25000)};
        ctr_sel_in = 1'($urandom);
        comp_cycle_in = 1'b1;
        start_xover_in = 1'b1;
        tick(1);
        comp_cycle_in = 1'b0;
        start_xover_in = 1'b0;
        tick(k - 1);
        stop_xover_in = 1'b1;
        tick(1);
        stop_xover_in = 1'b0;
        t = 0;
        while (angle_ready_out !== 1'b1 && t < 5) begin
            tick(1);
            t++;
        end
        chk(angle_ready_out === 1'b1, "no ready after stop");
        exp_ang.push_back(e);
        angle_rd_req_in = 1'b1;
        tick(1);
        angle_rd_req_in = 1'b0;
        // A request in mid-shift must not restart the word
        tick(3);
        angle_rd_req_in = 1'b1;
        tick(1);
        angle_rd_req_in = 1'b0;
        tick(12);
        chk(angle_ready_out === 1'b0, "ready after read");
        stop_xover_in = 1'b1;
        tick(1);
        stop_xover_in = 1'b0;
        tick(3);
        chk(angle_ready_out === 1'b0, "stop while idle acted");
        $display("angle test with %0d cycles done", k);
    endtask

    task automatic vel_step(int w, bit f);
        if (f) begin
            fwd[w] = 1'b1;
            hi[w] = hi[w] + ((ph[w] == 2'h0) ? 10'h1 : 10'h0);
            ph[w] = ph[w] - 2'h1;
        end else begin
            rev[w] = 1'b1;
            hi[w] = hi[w] - ((ph[w] == 2'h3) ? 10'h1 : 10'h0);
            ph[w] = ph[w] + 2'h1;
        end
        tick(1);
        fwd = 6'h0;
        rev = 6'h0;
        tick(2 * SCYC);
    endtask

    task automatic vel_read(int w, int w2);
        int t, n0;
        n0 = n_vel;
        exp_vel.push_back({hi[w2], ph[w2]});
        vel_rd_sel_in = 3'(w);
        vel_rd_req_in = 1'b1;
        tick(1);
        vel_rd_sel_in = 3'(w2);
        tick(1);
        vel_rd_req_in = 1'b0;
        t = 0;
        while (n_vel == n0 && t < 40) begin
            tick(1);
            t++;
        end
        chk(n_vel == n0 + 1, "velocity answer count");
    endtask

    always @(posedge core_clk_in) begin
        if (vel_valid_out === 1'b1) begin
            n_vel++;
            cmp_vel(vel_word_out);
        end
        if (angle_ser_en_out === 1'b1) begin
            sh = {sh[10:0], angle_ser_data_out};
            nbits++;
        end else if (nbits != 0) begin
            cmp_ang(sh, nbits);
            nbits = 0;
        end
    end

    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 80000) begin
            fail("timeout");
            final_report();
        end
    end

    initial begin
        int ks[5];
        int n;
        void'($urandom(32'h2FEB37CA));
        ks = '{2, 100 + $urandom_range(3000), 100 + $urandom_range(3000),
            1234, 24900};
        for (int w = 0; w < NUM_WORDS; w++) begin
            hi[w] = 10'h0;
            ph[w] = 2'h0;
        end
        tick(3);
        rst_n_in = 1'b1;
        tick(2);
        foreach (ks[i]) angle_test(ks[i]);
        // Forward across the wrap, then backward below zero
        for (int s = 0; s < 5; s++) vel_step(0, 1'b1);
        vel_read(0, 0);
        for (int s = 0; s < 10; s++) vel_step(0, 1'b0);
        vel_read(0, 0);
        for (int w = 0; w < NUM_WORDS; w++) begin
            n = 4 + $urandom_range(6);
            for (int s = 0; s < n; s++) vel_step(w, 1'($urandom));
            vel_read(w, w);
        end
        // Back-to-back requests: only the later selection is served
        vel_read(2, 5);
        $display("velocity tests done");
        final_report();
    end
endmodule // test_inertial_platform_input_processing
